/* File: testbench/idbz_core_bench.sv */
/* bench for idbz_core with a byte memory model.
   assumes the five-cycle walk; targets with address bit 7 set are nine bits. */
`timescale 1ns/1ns
module idbz_core_bench;
  reg         clock = 0, rst_b = 0, start = 0, nine = 0, rbit8 = 0, seen = 0;
  reg  [7:0]  op = 0, mode = 0, rb = 0, disp = 0, rdata = 0;
  reg  [15:0] pc = 0;
  reg  [8:0]  mem [0:255];
  wire [15:0] maddr, pco;
  wire [8:0]  wdata;
  wire [7:0]  pswo;
  wire        rd, wr, pcl, busy, ill;
  integer     n_mismatch = 0, checks_done = 0, i;
  idbz_core dut (.clock(clock), .rst_b(rst_b), .start(start), .insn_op(op), .insn_mode(mode),
    .relative_branch_byte(rb), .displacement_reg(disp), .pc_in(pc), .psw_in(8'ha5),
    .mem_rdata(rdata), .mem_rbit8(rbit8), .mem_nine_bit(nine), .mem_addr(maddr), .mem_rd(rd),
    .mem_wr(wr), .mem_wdata(wdata), .pc_out(pco), .pc_load(pcl), .program_status_word(pswo),
    .busy(busy), .illegal(ill));
  initial forever #20 clock = ~clock;
  // read data follows the registered address within the same cycle,
  // since the core samples it at the edge after the address is launched
  always @* begin
    {rbit8, rdata} = mem[maddr[7:0]];
    nine = maddr[7];
  end
  always @(posedge clock) begin
    if (wr)
      mem[maddr[7:0]] <= wdata;
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one instruction; bounded wait for pc load or refusal
  task run(input [7:0] o, m, r, d, input [15:0] p);
    begin
      @(negedge clock);
      {op, mode, rb, disp, pc, start} = {o, m, r, d, p, 1'b1};
      @(negedge clock);
      start = 0;
      for (i = 0; i < 8 && !pcl && !ill; i = i + 1)
        @(negedge clock);
      seen = ill;
      if (i == 8) begin
        n_mismatch = n_mismatch + 1;
        final_report;
      end
      @(negedge clock);
    end
  endtask
  task t_reg_disp;
    begin
      {mem[2], mem[3], mem[8'h59]} = {9'h055, 9'h000, 9'h002};
      run(8'h32, 8'h03, 8'h04, 8'h04, 16'h1f03);
      chk(pco, 16'h1f06);
      chk(mem[8'h59], 16'h0101);
      run(8'h32, 8'h03, 8'h01, 8'h04, 16'h1f06);
      chk(pco, 16'h1f0a);
      chk(pswo, 16'h00a7);
      $display("reg_disp done");
    end
  endtask
  task t_edge;
    begin
      {mem[8'h7e], mem[8'h7f], mem[8'h40]} = {9'h0c0, 9'h000, 9'h000};
      run(8'h32, 8'h7f, 8'h10, 8'h80, 16'h0100);
      chk(mem[8'h40], 16'h00ff);
      chk(pco, 16'h0103);
      chk(pswo, 16'h00a5);
      $display("edge done");
    end
  endtask
  task t_off;
    begin
      {mem[0], mem[1], mem[8'h80]} = {9'h0c0, 9'h000, 9'h101};
      run(8'h32, 8'hc0, 8'hfe, 8'h00, 16'hffff);
      chk(mem[8'h80], 16'h0100);
      chk(pco, 16'h0000);
      chk(pswo, 16'h00a7);
      $display("off done");
    end
  endtask
  task t_bad;
    begin
      run(8'h33, 8'h83, 8'h00, 8'h00, 16'h0000);
      chk(seen, 16'h0001);
      run(8'h32, 8'h02, 8'h00, 8'h00, 16'h0000);
      chk(seen, 16'h0001);
      $display("bad done");
    end
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rst_b = 1;
    repeat (3) @(negedge clock);
    t_reg_disp;
    t_edge;
    t_off;
    t_bad;
    final_report;
  end
endmodule // idbz_core_bench

/* File: testbench/idbz_core_props.sv */
/* port assertions for idbz_core.
   assumes the bind below and one clock domain. */
`timescale 1ns/1ns
module idbz_core_props (
  input logic        clock,
  input logic        rst_b,
  input logic        start,
  input logic        busy,
  input logic [7:0]  insn_op,
  input logic [7:0]  insn_mode,
  input logic [7:0]  relative_branch_byte,
  input logic [7:0]  displacement_reg,
  input logic [15:0] pc_in,
  input logic [7:0]  psw_in,
  input logic [7:0]  mem_rdata,
  input logic        mem_rbit8,
  input logic        mem_nine_bit,
  input logic [15:0] mem_addr,
  input logic        mem_rd,
  input logic        mem_wr,
  input logic [8:0]  mem_wdata,
  input logic [15:0] pc_out,
  input logic        pc_load,
  input logic [7:0]  program_status_word,
  input logic        illegal
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // accepted start: right opcode, and bit 7 or bit 0 of byte two set
  wire go = start && !busy && insn_op == 8'h32 && (insn_mode[7] || insn_mode[0]);
  sequence s_reads; mem_rd ##1 mem_rd ##1 mem_rd; endsequence
  sequence s_finish; mem_wr && pc_load ##1 !busy; endsequence
  property p_ptr; logic [5:0] n;
    (go && !insn_mode[7], n = insn_mode[6:1]) |=> mem_addr == {9'h000, n, 1'b0} ##1
      mem_addr == {9'h000, n, 1'b1};
  endproperty
  // the sum is 16 bits wide on purpose so that it wraps
  property p_disp; logic [7:0] d, lo, hi;
    (go && !insn_mode[7], d = displacement_reg) ##1 (1, lo = mem_rdata)
      ##1 (1, hi = mem_rdata) |=>
      mem_addr == {hi, lo} + {{8{d[7]}}, d};
  endproperty
  property p_off; logic [6:0] o; logic [7:0] lo, hi;
    (go && insn_mode[7], o = insn_mode[6:0]) ##1 (1, lo = mem_rdata)
      ##1 (1, hi = mem_rdata) |=>
      mem_addr == {hi, lo} + {{9{o[6]}}, o};
  endproperty
  property p_pc; logic [15:0] p; logic [7:0] r;
    (go, p = pc_in, r = relative_branch_byte) ##4 pc_load |->
      pc_out == p + 16'h0003 + (mem_wdata[7:0] == 8'h00 ? {{8{r[7]}}, r} : 16'h0000);
  endproperty
  property p_psw; logic [7:0] s;
    (go, s = psw_in) ##4 pc_load |-> program_status_word == {s[7:2], mem_wdata[8], s[0]};
  endproperty
  a_walk_order: assert property (go |=> s_reads ##1 s_finish)
    else $error("walk out of order");
  a_bad_code: assert property (start && !busy && !go |=> illegal && !mem_rd)
    else $error("bad encoding accepted");
  a_ptr_bytes: assert property (p_ptr)
    else $error("pointer bytes wrong");
  a_disp_addr: assert property (p_disp)
    else $error("displacement address wrong");
  a_off_addr: assert property (p_off)
    else $error("offset address wrong");
  a_dec_value: assert property (mem_wr |-> mem_wdata == {!mem_nine_bit || mem_rbit8, mem_rdata} - 9'h001)
    else $error("decrement wrong");
  a_pc_next: assert property (p_pc)
    else $error("pc wrong");
  a_psw_flag: assert property (p_psw)
    else $error("status word wrong");
endmodule // idbz_core_props
bind idbz_core idbz_core_props chk (.*);

/* File: verilog/idbz_core.v */
/*
  execution of decrement_branch_if_zero in its two indirect forms
  ([pointer, displacement register] and [base pointer, offset]).
  assumes a single-cycle memory read port (data valid in the same cycle as the
  address), a write port, a nine_bit flag from the memory map, and a
  start pulse with the three instruction bytes already fetched.
*/
`timescale 1ns/1ns
`include "idbz_regs.vh"
module idbz_core #(
  parameter ADDR_W = `IDBZ_ADDR_W
) (
  input  wire              clock,
  input  wire              rst_b,
  input  wire              start,
  input  wire [7:0]        insn_op,
  input  wire [7:0]        insn_mode,
  input  wire [7:0]        relative_branch_byte,
  input  wire [7:0]        displacement_reg,
  input  wire [ADDR_W-1:0] pc_in,
  input  wire [7:0]        psw_in,
  input  wire [7:0]        mem_rdata,
  input  wire              mem_rbit8,
  input  wire              mem_nine_bit,
  output reg  [ADDR_W-1:0] mem_addr,
  output reg               mem_rd,
  output reg               mem_wr,
  output reg  [8:0]        mem_wdata,
  output reg  [ADDR_W-1:0] pc_out,
  output reg               pc_load,
  output reg  [7:0]        program_status_word,
  output reg               busy,
  output reg               illegal
);
  localparam S_IDLE = 3'h0;
  localparam S_PLO  = 3'h1;
  localparam S_PHI  = 3'h2;
  localparam S_OPND = 3'h3;
  localparam S_WB   = 3'h4;

  // reset release through two flops
  reg rst_s1;
  reg rst_s2;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  reg  [2:0]        state;
  reg               use_off;
  reg  [7:0]        ptr_lo;
  reg  [ADDR_W-1:0] ptr_base;
  reg  [ADDR_W-1:0] disp_ext;
  reg  [7:0]        branch;
  reg  [ADDR_W-1:0] pc_hold;

  // decode: both forms share opcode 32h, split by bit 7 of byte two
  wire op_hit   = (insn_op == `IDBZ_OPCODE);
  wire form_off = insn_mode[`IDBZ_MODE_BIT];
  wire form_dsp = !insn_mode[`IDBZ_MODE_BIT] && insn_mode[`IDBZ_DISP_BIT];
  // full six-bit index, no range check needed: 0..63 are all legal
  wire [5:0] idx = insn_mode[`IDBZ_IDX_HI:`IDBZ_IDX_LO];

  // sign extension of the two displacement sources to address width
  wire [ADDR_W-1:0] off_ext = {{(ADDR_W-7){insn_mode[`IDBZ_OFF_SIGN]}},
                               insn_mode[`IDBZ_OFF_HI:0]};
  wire [ADDR_W-1:0] creg_ext = {{(ADDR_W-8){displacement_reg[7]}},
                                displacement_reg};

  // pointer n lives at bytes 2n (low) and 2n+1 (high)
  wire [ADDR_W-1:0] ptr_addr = `IDBZ_PTR_BASE + {{(ADDR_W-7){1'b0}}, idx, 1'b0};

  // missing ninth bit is taken as one
  wire [8:0] operand = {mem_nine_bit ? mem_rbit8 : 1'b1, mem_rdata};
  wire [8:0] dec_res;
  wire       dec_zero;

  idbz_dec9 u_dec (
    .operand  (operand),
    .result   (dec_res),
    .low_zero (dec_zero)
  );

  wire [ADDR_W-1:0] pc_next = pc_hold + `IDBZ_INSN_LEN;
  wire [ADDR_W-1:0] br_ext  = {{(ADDR_W-8){branch[7]}}, branch};

  // sequencer: pointer low, pointer high, operand read, write back
  always @(posedge clock or negedge rst_s2) begin
    if (!rst_s2) begin
      state               <= S_IDLE;
      use_off             <= 1'b0;
      ptr_lo              <= 8'h00;
      ptr_base            <= {ADDR_W{1'b0}};
      disp_ext            <= {ADDR_W{1'b0}};
      branch              <= 8'h00;
      pc_hold             <= `IDBZ_PC_RESET;
      mem_addr            <= {ADDR_W{1'b0}};
      mem_rd              <= 1'b0;
      mem_wr              <= 1'b0;
      mem_wdata           <= 9'h000;
      pc_out              <= `IDBZ_PC_RESET;
      pc_load             <= 1'b0;
      program_status_word <= `IDBZ_PSW_RESET;
      busy                <= 1'b0;
      illegal             <= 1'b0;
    end else begin
      mem_rd  <= 1'b0;
      mem_wr  <= 1'b0;
      pc_load <= 1'b0;
      illegal <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            if (op_hit && (form_off || form_dsp)) begin
              use_off  <= form_off;
              branch   <= relative_branch_byte;
              pc_hold  <= pc_in;
              program_status_word <= psw_in;
              disp_ext <= form_off ? off_ext : creg_ext;
              // offset form always reads pointer zero
              mem_addr <= form_off ? `IDBZ_PTR_BASE : ptr_addr;
              mem_rd   <= 1'b1;
              busy     <= 1'b1;
              state    <= S_PLO;
            end else begin
              illegal <= 1'b1;   // not one of ours, e.g. bit 7 and bit 0 both clear
            end
          end
        end
        S_PLO: begin
          ptr_lo   <= mem_rdata;
          mem_addr <= mem_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
          mem_rd   <= 1'b1;
          state    <= S_PHI;
        end
        S_PHI: begin
          ptr_base <= {mem_rdata, ptr_lo};
          // wraps modulo 2^16, no fault raised
          mem_addr <= {mem_rdata, ptr_lo} + disp_ext;
          mem_rd   <= 1'b1;
          state    <= S_OPND;
        end
        S_OPND: begin
          mem_wdata <= dec_res;
          mem_wr    <= 1'b1;
          program_status_word[`IDBZ_PSW_CARRY_BIT] <= dec_res[8];
          pc_out    <= dec_zero ? (pc_next + br_ext) : pc_next;
          pc_load   <= 1'b1;
          state     <= S_WB;
        end
        S_WB: begin
          busy  <= 1'b0;
          state <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
endmodule // idbz_core

/* File: verilog/idbz_dec9.v */
/*
  nine-bit decrement with an eight-bit zero test.
  assumes the caller supplies bit 8 as 1 when the target has no ninth bit.
*/
`timescale 1ns/1ns
module idbz_dec9 (
  input  wire [8:0] operand,
  output wire [8:0] result,
  output wire       low_zero
);
  // wraps from 000h to 1ffh; only the low byte decides the branch
  assign result   = operand - 9'h001;
  assign low_zero = (result[7:0] == 8'h00);
endmodule // idbz_dec9

/* File: verilog/idbz_regs.vh */
/*
  constants for the indirect decrement-and-branch-if-zero execution block:
  opcode, field positions, pointer layout, flag position and reset values.
  assumes inclusion by bare name from the design files only.
*/
`ifndef IDBZ_REGS_VH
`define IDBZ_REGS_VH

`define IDBZ_OPCODE          8'h32
`define IDBZ_MODE_BIT        7
`define IDBZ_IDX_HI          6
`define IDBZ_IDX_LO          1
`define IDBZ_DISP_BIT        0
`define IDBZ_OFF_HI          6
`define IDBZ_OFF_SIGN        6
`define IDBZ_INSN_LEN        16'h0003
`define IDBZ_PSW_CARRY_BIT   1
`define IDBZ_ADDR_W          16
`define IDBZ_PTR_BASE        16'h0000
`define IDBZ_PSW_RESET       8'h00
`define IDBZ_PC_RESET        16'h0000

`endif
